//--- shared/flash_cmd_pkg.sv
// flash_cmd_pkg: opcodes, command classes, latencies and reset values
// for the suspend/resume and write-enable command logic.
// assumes a 50 MHz core clock that samples the serial link pins.
package flash_cmd_pkg;

   // core clock rate and derived latencies (longest times round down)
   localparam int CLOCK_KHZ           = 50000;
   localparam int RESUME_LATENCY_NS   = 40000;
   localparam int SUSPEND_LATENCY_NS  = 20000;
   localparam int RESUME_CYCLES       = RESUME_LATENCY_NS * CLOCK_KHZ / 1000000;
   localparam int SUSPEND_CYCLES      = SUSPEND_LATENCY_NS * CLOCK_KHZ / 1000000;
   localparam int LAT_W               = 12;

   // opcodes
   localparam logic [7:0] OP_RESUME      = 8'hd0;
   localparam logic [7:0] OP_SUSPEND     = 8'hb0;
   localparam logic [7:0] OP_WRITE_EN    = 8'h06;
   localparam logic [7:0] OP_WRITE_DIS   = 8'h04;
   localparam logic [7:0] OP_CHIP_ERASE0 = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE1 = 8'hc7;
   localparam logic [7:0] OP_PROTECT     = 8'h36;
   localparam logic [7:0] OP_UNPROTECT   = 8'h39;
   localparam logic [7:0] OP_PROGRAM     = 8'h02;
   localparam logic [7:0] OP_ERASE_4K    = 8'h20;
   localparam logic [7:0] OP_ERASE_32K   = 8'h52;
   localparam logic [7:0] OP_ERASE_64K   = 8'hd8;
   localparam logic [7:0] OP_LOCKDOWN    = 8'h33;
   localparam logic [7:0] OP_FREEZE_LOCK = 8'h34;
   localparam logic [7:0] OP_OTP_PROGRAM = 8'h9b;
   localparam logic [7:0] OP_WRITE_STAT  = 8'h01;
   localparam logic [7:0] OP_WRITE_CFG   = 8'h3f;
   localparam logic [7:0] OP_POWER_DOWN  = 8'hb9;
   localparam logic [7:0] OP_WAKE        = 8'hab;
   localparam logic [7:0] OP_SOFT_RESET  = 8'hf0;

   // sector field of the 24-bit address and least frame lengths in bytes
   localparam int         SECTOR_MSB     = 23;
   localparam int         SECTOR_LSB     = 16;
   localparam logic [2:0] ADDR_BYTES_MIN = 3'h4;
   localparam logic [2:0] PROG_BYTES_MIN = 3'h5;

   // values after reset
   localparam logic WEL_RST  = 1'b0;
   localparam logic PS_RST   = 1'b0;
   localparam logic ES_RST   = 1'b0;
   localparam logic BUSY_RST = 1'b0;

   typedef enum logic [1:0] {
      ST_IDLE       = 2'b00,
      ST_RUN        = 2'b01,
      ST_SUSPENDING = 2'b10,
      ST_RESUMING   = 2'b11
   } op_state_t;

   typedef enum logic [3:0] {
      CL_OTHER   = 4'h0,
      CL_WREN    = 4'h1,
      CL_WRDI    = 4'h2,
      CL_SUSPEND = 4'h3,
      CL_RESUME  = 4'h4,
      CL_PROGRAM = 4'h5,
      CL_ERASE   = 4'h6,
      CL_CHIP    = 4'h7,
      CL_GUARDED = 4'h8,
      CL_BANNED  = 4'h9,
      CL_RESET   = 4'ha
   } cmd_class_t;

   // map an opcode onto its handling class; reads fall into CL_OTHER
   function automatic cmd_class_t cmd_class(input logic [7:0] op);
      cmd_class_t c;
      c = CL_OTHER;
      if (op == OP_WRITE_EN) c = CL_WREN;
      else if (op == OP_WRITE_DIS) c = CL_WRDI;
      else if (op == OP_SUSPEND) c = CL_SUSPEND;
      else if (op == OP_RESUME) c = CL_RESUME;
      else if (op == OP_PROGRAM) c = CL_PROGRAM;
      else if (op == OP_ERASE_4K || op == OP_ERASE_32K ||
               op == OP_ERASE_64K) c = CL_ERASE;
      else if (op == OP_CHIP_ERASE0 || op == OP_CHIP_ERASE1) c = CL_CHIP;
      else if (op == OP_PROTECT || op == OP_UNPROTECT ||
               op == OP_LOCKDOWN || op == OP_FREEZE_LOCK ||
               op == OP_OTP_PROGRAM || op == OP_WRITE_STAT ||
               op == OP_WRITE_CFG) c = CL_GUARDED;
      else if (op == OP_POWER_DOWN || op == OP_WAKE) c = CL_BANNED;
      else if (op == OP_SOFT_RESET) c = CL_RESET;
      return c;
   endfunction

endpackage

//--- rtl/flash_suspend_resume_wel_ctrl.sv
// flash_suspend_resume_wel_ctrl: opcode gating during suspend, resume
// and suspend sequencing, and the write enable latch of a serial flash.
// assumes the link pins arrive asynchronously at well under 1/4 of the
// core clock rate, and an array core that times program and erase.
//
// Operation
// - reset during erase suspend abandons that erase
// - reset during program suspend abandons that program
// - disallowed opcode while suspended does nothing
// - ignored opcode leaves latch and lock bits alone
// - reads, resume, reset, id allowed while suspended
// - erase, protect, lock, writes, power-down refused in either suspend
// - program, suspend, wren, wrdi refused in program suspend
// - resume is lone opcode; trailing bytes ignored
// - resume works whatever the latch holds
// - resume on release: clear flag, go busy
// - resume only on whole-byte release
// - both suspended: program resumes before erase
// - suspend ignored while resume is in progress
// - write enable opcode sets latch on release
// - short or ragged write enable leaves latch alone
// - modifying commands need the latch set
// - suspend opcode: flag set, ready, no latch needed
// - reads in a suspended sector return undefined
// - program into erase-suspended sector aborts, latch clears
`timescale 1ns/10ps
module flash_suspend_resume_wel_ctrl
   import flash_cmd_pkg::*;
#(
   parameter int RESUME_CYC  = RESUME_CYCLES,
   parameter int SUSPEND_CYC = SUSPEND_CYCLES
) (
   input  wire logic        clock_i,                  // core clock
   input  wire logic        srst_i,                   // sync reset, high
   input  wire logic        spi_cs_n_i,               // chip select pin
   input  wire logic        spi_sck_i,                // serial clock pin
   input  wire logic        spi_mosi_i,               // serial data in
   input  wire logic        op_done_i,                // array op finished
   input  wire logic [7:0]  read_sector_i,            // sector being read
   output logic             write_enable_latch_o,     // latch state
   output logic             program_suspended_flag_o, // program parked
   output logic             erase_suspended_flag_o,   // erase parked
   output logic             ready_busy_flag_o,        // 1 = busy
   output logic             core_run_o,               // array may work
   output logic             core_erase_o,             // running op kind
   output logic             exec_o,                   // command pulse
   output logic [7:0]       exec_opcode_o,            // its opcode
   output logic [23:0]      exec_addr_o,              // its address
   output logic             program_abandon_o,        // drop parked prog
   output logic             erase_abandon_o,          // drop parked erase
   output logic             read_undefined_o          // read data invalid
);

   ////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [1:0]  cs_sync;
      logic [1:0]  sck_sync;
      logic [1:0]  mosi_sync;
      logic        cs_prev;
      logic        sck_prev;
      logic [6:0]  shift;
      logic [2:0]  bit_cnt;
      logic [2:0]  byte_cnt;
      logic [7:0]  opcode;
      logic [23:0] addr;
      logic        wel;
      logic        ps;
      logic        es;
      logic        busy;
      op_state_t   op_state;
      logic        op_is_erase;
      logic [7:0]  active_sector;
      logic [7:0]  prog_sector;
      logic [7:0]  erase_sector;
      logic [LAT_W-1:0] lat_cnt;
      logic        exec;
      logic [7:0]  exec_op;
      logic [23:0] exec_addr;
      logic        prog_abandon;
      logic        erase_abandon;
      logic        read_undef;
   } ctrl_state_t;

   ctrl_state_t st;
   ctrl_state_t next_st;

   logic       sck_rise;
   logic       frame_end;
   logic [7:0] byte_in;
   logic       whole_bytes;
   logic       suspended;
   logic       refused;
   cmd_class_t cls;

   ////////////////////////////////////////////////////////////////////
   // link decode helpers, all on second-stage synchronised pins

   assign sck_rise  = st.sck_sync[1] & ~st.sck_prev;
   assign frame_end = st.cs_sync[1] & ~st.cs_prev;
   assign byte_in   = {st.shift, st.mosi_sync[1]};
   // at least one full byte and released on a byte boundary
   assign whole_bytes = (st.byte_cnt != 3'h0) && (st.bit_cnt == 3'h0);
   assign suspended   = st.ps | st.es;
   assign cls         = cmd_class(st.opcode);

   // refusal table for the suspend states
   always_comb begin
      refused = 1'b0;
      if (suspended) begin
         if (cls == CL_ERASE || cls == CL_CHIP || cls == CL_GUARDED ||
             cls == CL_BANNED) begin
            refused = 1'b1;
         end
      end
      if (st.ps) begin
         if (cls == CL_PROGRAM || cls == CL_SUSPEND || cls == CL_WREN ||
             cls == CL_WRDI) begin
            refused = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_st = st;

      // two-stage synchronisers; first stage feeds only the second
      next_st.cs_sync   = {st.cs_sync[0], spi_cs_n_i};
      next_st.sck_sync  = {st.sck_sync[0], spi_sck_i};
      next_st.mosi_sync = {st.mosi_sync[0], spi_mosi_i};
      next_st.cs_prev   = st.cs_sync[1];
      next_st.sck_prev  = st.sck_sync[1];

      // pulses last one cycle
      next_st.exec          = 1'b0;
      next_st.prog_abandon  = 1'b0;
      next_st.erase_abandon = 1'b0;

      // bit gathering while selected; byte count saturates at 7
      if (st.cs_sync[1]) begin
         next_st.bit_cnt  = 3'h0;
         next_st.byte_cnt = 3'h0;
      end else if (sck_rise) begin
         next_st.shift   = byte_in[6:0];
         next_st.bit_cnt = st.bit_cnt + 3'h1;
         if (st.bit_cnt == 3'h7) begin
            if (st.byte_cnt == 3'h0) begin
               next_st.opcode = byte_in;
            end else if (st.byte_cnt < ADDR_BYTES_MIN) begin
               next_st.addr = {st.addr[15:0], byte_in};
            end
            if (st.byte_cnt != 3'h7) begin
               next_st.byte_cnt = st.byte_cnt + 3'h1;
            end
         end
      end

      // suspend and resume latency sequencing
      case (st.op_state)
         ST_RUN: begin
            if (op_done_i) begin
               next_st.op_state = ST_IDLE;
               next_st.busy     = 1'b0;
               next_st.wel      = 1'b0;
            end
         end
         ST_SUSPENDING: begin
            if (st.lat_cnt == '0) begin
               next_st.op_state = ST_IDLE;
               next_st.busy     = 1'b0;
               if (st.op_is_erase) begin
                  next_st.es           = 1'b1;
                  next_st.erase_sector = st.active_sector;
               end else begin
                  next_st.ps          = 1'b1;
                  next_st.prog_sector = st.active_sector;
               end
            end else begin
               next_st.lat_cnt = st.lat_cnt - 1'b1;
            end
         end
         ST_RESUMING: begin
            if (st.lat_cnt == '0) begin
               next_st.op_state = ST_RUN;
            end else begin
               next_st.lat_cnt = st.lat_cnt - 1'b1;
            end
         end
         default: begin
         end
      endcase

      // command execution on chip select release; trailing bytes of
      // single-opcode commands are never looked at
      if (frame_end && whole_bytes) begin
         if (refused) begin
            // nothing: latch and lock bits stay as they were
            next_st.exec = 1'b0;
         end else begin
            case (cls)
               CL_WREN: begin
                  next_st.wel = 1'b1;
               end
               CL_WRDI: begin
                  next_st.wel = 1'b0;
               end
               CL_RESUME: begin
                  // latch not consulted
                  if (st.op_state == ST_IDLE && st.ps) begin
                     next_st.ps            = 1'b0;
                     next_st.op_is_erase   = 1'b0;
                     next_st.active_sector = st.prog_sector;
                     next_st.busy          = 1'b1;
                     next_st.op_state      = ST_RESUMING;
                     next_st.lat_cnt       = LAT_W'(RESUME_CYC - 1);
                  end else if (st.op_state == ST_IDLE && st.es) begin
                     next_st.es            = 1'b0;
                     next_st.op_is_erase   = 1'b1;
                     next_st.active_sector = st.erase_sector;
                     next_st.busy          = 1'b1;
                     next_st.op_state      = ST_RESUMING;
                     next_st.lat_cnt       = LAT_W'(RESUME_CYC - 1);
                  end
               end
               CL_SUSPEND: begin
                  // only a running op; resuming ops ignore it
                  if (st.op_state == ST_RUN) begin
                     next_st.op_state = ST_SUSPENDING;
                     next_st.lat_cnt  = LAT_W'(SUSPEND_CYC - 1);
                  end
               end
               CL_RESET: begin
                  // parked work is dropped; the array core marks it
                  if (st.es) begin
                     next_st.erase_abandon = 1'b1;
                     next_st.es            = 1'b0;
                  end
                  if (st.ps) begin
                     next_st.prog_abandon = 1'b1;
                     next_st.ps           = 1'b0;
                  end
                  next_st.exec      = 1'b1;
                  next_st.exec_op   = st.opcode;
                  next_st.exec_addr = st.addr;
               end
               CL_PROGRAM, CL_ERASE, CL_CHIP: begin
                  if (!st.wel) begin
                     next_st.wel = 1'b0;
                  end else if (st.op_state != ST_IDLE) begin
                     next_st.wel = 1'b0;
                  end else if ((cls == CL_PROGRAM &&
                                st.byte_cnt < PROG_BYTES_MIN) ||
                               (cls == CL_ERASE &&
                                st.byte_cnt < ADDR_BYTES_MIN)) begin
                     next_st.wel = 1'b0;
                  end else if (cls == CL_PROGRAM && st.es &&
                               st.addr[SECTOR_MSB:SECTOR_LSB] ==
                               st.erase_sector) begin
                     next_st.wel = 1'b0;
                  end else begin
                     next_st.exec          = 1'b1;
                     next_st.exec_op       = st.opcode;
                     next_st.exec_addr     = st.addr;
                     next_st.busy          = 1'b1;
                     next_st.op_state      = ST_RUN;
                     next_st.op_is_erase   = (cls != CL_PROGRAM);
                     next_st.active_sector =
                        st.addr[SECTOR_MSB:SECTOR_LSB];
                  end
               end
               CL_GUARDED: begin
                  // executed only with the latch set; latch drops after
                  if (st.wel && st.op_state == ST_IDLE) begin
                     next_st.exec      = 1'b1;
                     next_st.exec_op   = st.opcode;
                     next_st.exec_addr = st.addr;
                  end
                  next_st.wel = 1'b0;
               end
               default: begin
                  // reads, id and other allowed commands pass on
                  next_st.exec      = 1'b1;
                  next_st.exec_op   = st.opcode;
                  next_st.exec_addr = st.addr;
               end
            endcase
         end
      end
      // a ragged or empty frame changes nothing

      // read data from a parked sector is flagged invalid
      next_st.read_undef = (st.ps && read_sector_i == st.prog_sector) ||
                           (st.es && read_sector_i == st.erase_sector);
      // registered one cycle so the flag follows read_sector_i

      if (srst_i) begin
         next_st           = '0;
         next_st.cs_sync   = 2'b11;
         next_st.cs_prev   = 1'b1;
         next_st.wel       = WEL_RST;
         next_st.ps        = PS_RST;
         next_st.es        = ES_RST;
         next_st.busy      = BUSY_RST;
         next_st.op_state  = ST_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clock_i) begin
      st <= next_st;
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, each straight from a state flop

   assign write_enable_latch_o     = st.wel;
   assign program_suspended_flag_o = st.ps;
   assign erase_suspended_flag_o   = st.es;
   assign ready_busy_flag_o        = st.busy;
   assign exec_o                   = st.exec;
   assign exec_opcode_o            = st.exec_op;
   assign exec_addr_o              = st.exec_addr;
   assign program_abandon_o        = st.prog_abandon;
   assign erase_abandon_o          = st.erase_abandon;
   assign read_undefined_o         = st.read_undef;

   // array works in run and while the suspend latency runs out
   logic core_run;
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         core_run <= 1'b0;
      end else begin
         core_run <= (next_st.op_state == ST_RUN) ||
                     (next_st.op_state == ST_SUSPENDING);
      end
   end
   assign core_run_o   = core_run;
   assign core_erase_o = st.op_is_erase;

endmodule

//--- verif/flash_ctrl_properties.sv
// flash_ctrl_properties: port-level checks on the command block.
// assumes binding onto the command block; one clock, sync reset.
`timescale 1ns/10ps
module flash_ctrl_properties
   import flash_cmd_pkg::*;
#(
   parameter int RESUME_CYC  = RESUME_CYCLES,
   parameter int SUSPEND_CYC = SUSPEND_CYCLES
) (
   input wire logic       clock_i,                  // core clock
   input wire logic       srst_i,                   // sync reset
   input wire logic       write_enable_latch_o,     // latch
   input wire logic       program_suspended_flag_o, // program parked
   input wire logic       erase_suspended_flag_o,   // erase parked
   input wire logic       ready_busy_flag_o,        // busy
   input wire logic       core_run_o,               // array working
   input wire logic       exec_o,                   // command pulse
   input wire logic [7:0] exec_opcode_o,            // its opcode
   input wire logic       program_abandon_o,        // program dropped
   input wire logic       erase_abandon_o           // erase dropped
);
   localparam int LIM = RESUME_CYC + SUSPEND_CYC + 4;
   wire logic wel = write_enable_latch_o;
   wire logic ps = program_suspended_flag_o;
   wire logic es = erase_suspended_flag_o;
   wire logic busy = ready_busy_flag_o;
   logic [LAT_W:0] wait_cnt;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);

   //////////////////////////////////////////////////////////////////////
   // busy without the core running may not outlast resume plus suspend latency and 4 cycles
   always_ff @(posedge clock_i) begin
      wait_cnt <= (srst_i || core_run_o || !busy) ? '0 : wait_cnt + 1'b1;
   end

   sequence s_resume_start;
      $fell(ps) && !program_abandon_o && !$past(program_abandon_o);
   endsequence
   sequence s_suspend_done;
      $rose(ps) || $rose(es);
   endsequence

   //////////////////////////////////////////////////////////////////////
   AST_RESET_CLEAR: assert property ($fell(srst_i) |-> !(wel||ps||es||busy))
      else $error("flags not clear after reset");
   AST_RESUME_BUSY: assert property (s_resume_start |-> busy)
      else $error("resume did not report busy");
   AST_RESUME_RUN: assert property (wait_cnt <= LIM)
      else $error("resumed operation did not restart in time");
   AST_SUSPEND_READY: assert property ($rose(ps) |-> !busy ##1 !core_run_o)
      else $error("suspend did not report ready");
   AST_SUSPEND_FROM_RUN: assert property (s_suspend_done |-> $past(core_run_o))
      else $error("suspend taken while not running");
   AST_PS_LATCH: assert property (ps && $past(ps) |-> $stable(wel))
      else $error("latch moved during program suspend");
   AST_PS_REFUSED: assert property (exec_o && ps && $past(ps) |->
      !(exec_opcode_o inside {8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h36,
      8'h39, 8'h33, 8'h34, 8'h9b, 8'h01, 8'h3f, 8'hb9, 8'hab, 8'h02,
      8'hb0, 8'h06, 8'h04}))
      else $error("refused command executed in program suspend");
   AST_EXEC_NEEDS_WEL: assert property (exec_o && (exec_opcode_o inside
      {8'h02, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h36, 8'h39, 8'h33,
      8'h34, 8'h9b, 8'h01, 8'h3f}) |-> $past(wel))
      else $error("modifying command executed with latch clear");
   AST_PROGRAM_FIRST: assert property ($fell(es) && !erase_abandon_o &&
      !$past(erase_abandon_o) |-> !ps)
      else $error("erase resumed before program");
endmodule

bind flash_suspend_resume_wel_ctrl flash_ctrl_properties #(
   .RESUME_CYC (RESUME_CYC),
   .SUSPEND_CYC(SUSPEND_CYC)
) u_props (
   .clock_i(clock_i),
   .srst_i(srst_i),
   .write_enable_latch_o(write_enable_latch_o),
   .program_suspended_flag_o(program_suspended_flag_o),
   .erase_suspended_flag_o(erase_suspended_flag_o),
   .ready_busy_flag_o(ready_busy_flag_o),
   .core_run_o(core_run_o),
   .exec_o(exec_o),
   .exec_opcode_o(exec_opcode_o),
   .program_abandon_o(program_abandon_o),
   .erase_abandon_o(erase_abandon_o)
);

//--- verif/flash_host_model.sv
// flash_host_model: serial host sending opcode frames to the flash.
// assumes frames are started on a falling edge of the core clock.
`timescale 1ns/10ps
module flash_host_model (
   output logic spi_cs_n_o, // chip select, low active
   output logic spi_sck_o,  // serial clock, still between frames
   output logic spi_mosi_o  // serial data, msb first
);
   initial begin
      spi_cs_n_o = 1'b1;
      spi_sck_o = 1'b0;
      spi_mosi_o = 1'b0;
   end

   //////////////////////////////////////////////////////////////////////
   // one frame of nb bits; lone opcodes may carry ignored trailing bytes
   task automatic frame(input logic [39:0] d, input int nb);
      spi_cs_n_o = 1'b0;
      for (int i = 0; i < nb; i++) begin
         spi_mosi_o = d[39-i];
         #80 spi_sck_o = 1'b1;
         #80 spi_sck_o = 1'b0;
      end
      #40 spi_cs_n_o = 1'b1;
      spi_mosi_o = ~spi_mosi_o; // released line must not keep its level
      #100;
   endtask
endmodule

//--- verif/flash_suspend_resume_wel_ctrl_test.sv
// flash_suspend_resume_wel_ctrl_test: self-checking bench for the block.
// assumes the host model drives the link; core events come from here.
`timescale 1ns/10ps
module flash_suspend_resume_wel_ctrl_test;
   import flash_cmd_pkg::*;
   localparam int RES = 200;
   localparam int SUS = 3;
   logic       clock_i = 1'b0;
   logic       srst_i = 1'b1;
   logic       op_done_i = 1'b0;
   logic [7:0] read_sector_i = 8'h00;
   logic       cs_n, sck, mosi, wel, ps, es, busy, undef, exec, eab;
   logic       pab, cerase;
   logic [7:0] xop;
   logic [23:0] xaddr;
   int         n_pab = 0;
   int         n_mismatch = 0;
   int         checks = 0;
   int         seed = 38;
   int         n_exec = 0;
   int         n_ab = 0;

   always #10 clock_i = ~clock_i;

   flash_host_model u_host (.spi_cs_n_o(cs_n), .spi_sck_o(sck),
      .spi_mosi_o(mosi));
   flash_suspend_resume_wel_ctrl #(.RESUME_CYC(RES), .SUSPEND_CYC(SUS)) u_dut (
      .clock_i(clock_i), .srst_i(srst_i), .spi_cs_n_i(cs_n),
      .spi_sck_i(sck), .spi_mosi_i(mosi), .op_done_i(op_done_i),
      .read_sector_i(read_sector_i), .write_enable_latch_o(wel),
      .program_suspended_flag_o(ps), .erase_suspended_flag_o(es),
      .ready_busy_flag_o(busy), .core_run_o(), .core_erase_o(cerase),
      .exec_o(exec), .exec_opcode_o(xop), .exec_addr_o(xaddr),
      .program_abandon_o(pab), .erase_abandon_o(eab),
      .read_undefined_o(undef));

   //////////////////////////////////////////////////////////////////////
   // pulse counters; pulses stand one cycle only
   always @(posedge clock_i) begin
      if (exec === 1'b1) n_exec++;
      if (eab === 1'b1) n_ab++;
      if (pab === 1'b1) n_pab++;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // frame with random address tail, then flags {wel,ps,es,busy}
   task automatic step(input logic [7:0] op, input logic [7:0] sec,
                       input int nb, input logic [3:0] e);
      u_host.frame({op, sec, 24'($random(seed))}, nb);
      repeat (12) @(negedge clock_i);
      chk("flags", {28'h0, e}, {28'h0, wel, ps, es, busy});
   endtask

   // refused in either suspend, plus the four refused in program suspend
   function automatic logic refused(input logic [7:0] op, input logic p);
      return cmd_class(op) inside {CL_ERASE, CL_CHIP, CL_GUARDED,
         CL_BANNED} || (p && op inside {OP_PROGRAM, OP_SUSPEND,
         OP_WRITE_EN, OP_WRITE_DIS});
   endfunction

   task automatic done_pulse();
      repeat (RES + 20) @(negedge clock_i);
      op_done_i = 1'b1;
      @(negedge clock_i);
      op_done_i = 1'b0;
   endtask

   //////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] ops [19] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h36,
         8'h39, 8'h33, 8'h34, 8'h9b, 8'h01, 8'h3f, 8'hb9, 8'hab, 8'h02,
         8'hb0, 8'h06, 8'h04, 8'h03};
      int e;
      repeat (3) @(negedge clock_i);
      srst_i = 1'b0;
      repeat (4) @(negedge clock_i);
      chk("flags", 32'h0, {28'h0, wel, ps, es, busy});
      step(OP_WRITE_EN, 8'h00, 7, 4'b0000);
      step(OP_WRITE_EN, 8'h00, 16, 4'b1000);
      e = n_exec;
      step(OP_PROGRAM, 8'h05, 40, 4'b1001);
      chk("exec", e + 1, n_exec);
      chk("opcode", {24'h0, OP_PROGRAM}, {24'h0, xop});
      chk("sector", 32'h5, {24'h0, xaddr[23:16]});
      chk("kind", 32'h0, {31'h0, cerase});
      step(OP_SUSPEND, 8'h00, 8, 4'b1100);
      read_sector_i = 8'h05;
      repeat (3) @(negedge clock_i);
      chk("undef", 32'h1, {31'h0, undef});
      read_sector_i = 8'h06;
      repeat (3) @(negedge clock_i);
      chk("undef", 32'h0, {31'h0, undef});
      foreach (ops[i]) begin
         e = n_exec;
         step(ops[i], 8'($random(seed)), 40, 4'b1100);
         chk("exec", e + int'(!refused(ops[i], 1'b1)), n_exec);
      end
      step(OP_RESUME, 8'h00, 12, 4'b1100);
      step(OP_RESUME, 8'h00, 16, 4'b1001);
      step(OP_SUSPEND, 8'h00, 8, 4'b1001);
      done_pulse();
      step(OP_PROGRAM, 8'h03, 40, 4'b0000);
      step(OP_WRITE_EN, 8'h00, 8, 4'b1000);
      step(OP_ERASE_4K, 8'h07, 32, 4'b1001);
      chk("kind", 32'h1, {31'h0, cerase});
      step(OP_SUSPEND, 8'h00, 8, 4'b1010);
      step(OP_PROGRAM, 8'h07, 40, 4'b0010);
      step(OP_WRITE_EN, 8'h00, 8, 4'b1010);
      step(OP_PROGRAM, 8'h09, 40, 4'b1011);
      step(OP_SUSPEND, 8'h00, 8, 4'b1110);
      step(OP_RESUME, 8'h00, 8, 4'b1011);
      done_pulse();
      chk("flags", 32'h2, {28'h0, wel, ps, es, busy});
      step(OP_RESUME, 8'h00, 8, 4'b0001);
      repeat (RES + 20) @(negedge clock_i);
      step(OP_SUSPEND, 8'h00, 8, 4'b0010);
      e = n_ab;
      step(OP_SOFT_RESET, 8'h00, 8, 4'b0000);
      chk("abandon", e + 1, n_ab);
      step(OP_WRITE_EN, 8'h00, 8, 4'b1000);
      step(OP_PROGRAM, 8'h0b, 40, 4'b1001);
      step(OP_SUSPEND, 8'h00, 8, 4'b1100);
      e = n_pab;
      step(OP_SOFT_RESET, 8'h00, 8, 4'b1000);
      chk("abandon", e + 1, n_pab);
      conclude();
   end

   // watchdog well beyond the expected run of about 10700 cycles
   initial begin
      #1000000;
      n_mismatch++;
      conclude();
   end
endmodule
